//--- design/afr_pkg.sv
// package for the frame-type classifier and rewrite-action decoder
// Operation
// [R1] rewrite mode is four bits; zero leaves routing and MAC handling alone
// [R2] routing mode: bit0 enables unicast, bit1 multicast routing updates
// [R3] routing mode bit2 makes the action MAC carry control fields
// [R4] swapping sub-mode 0 replaces destination MAC, 1 replaces source MAC
// [R5] sub-modes 2-4 swap MACs, replace source MAC if new source is multicast
// [R6] sub-mode 5 swaps MAC/IP if destination unicast, else replaces source
// [R7] sub-mode 6 swaps IPs, replacing source IP if new one is multicast
// [R8] sub-mode 7 replaces source MAC and swaps IPs with multicast fallback
// [R9] replaced MAC addresses come from the action MAC value
// [R10] replaced source IP comes from the table entry at the policer index
// [R11] mode bits 3:2 equal 1: MAC bit0 override enable, bits 6:1 index
// [R12] overloaded MAC bit16 selects bits 26:17 as dual-bucket policer index
// [R13] two-bit domain select picks timing domain settings for delay responses
// [R14] every frame falls into exactly one of nine frame types
// [R15] type 0x86dd version 6 is IPv6, multicast when address in ff00::/8
// [R16] type 0x800 version 4 is IPv4, multicast when address in 224.0.0.0/4
// [R17] IP protocol 0x6 is TCP, 0x11 UDP, anything else other
// [R18] type 0x0806 or 0x8035 is address resolution
// [R19] type 0x8902 is OAM
// [R20] length below 0x600 with aa/aa/03 LLC header is SNAP
// [R21] length below 0x600 without SNAP pattern is LLC
// [R22] type 0x600 or above matching nothing else is generic EtherType
// [R23] classification uses the type field after any VLAN tags; the code skips at most three 0x8100/0x88a8 tags
package afr_pkg;

  // ---------------------------------------------------------------
  // frame classification constants
  // ---------------------------------------------------------------
  localparam logic [15:0] AFR_ET_IPV6 = 16'h86dd;
  localparam logic [15:0] AFR_ET_IPV4 = 16'h0800;
  localparam logic [15:0] AFR_ET_ARP = 16'h0806;
  localparam logic [15:0] AFR_ET_RARP = 16'h8035;
  localparam logic [15:0] AFR_ET_OAM = 16'h8902;
  localparam logic [15:0] AFR_ET_VLAN_C = 16'h8100;
  localparam logic [15:0] AFR_ET_VLAN_S = 16'h88a8;
  localparam logic [15:0] AFR_LEN_LIMIT = 16'h0600;
  localparam logic [3:0] AFR_IPVER_4 = 4'h4;
  localparam logic [3:0] AFR_IPVER_6 = 4'h6;
  localparam logic [7:0] AFR_V6_MC_PFX = 8'hff;
  localparam logic [3:0] AFR_V4_MC_PFX = 4'he;
  localparam logic [7:0] AFR_PROTO_TCP = 8'h06;
  localparam logic [7:0] AFR_PROTO_UDP = 8'h11;
  localparam logic [7:0] AFR_SNAP_SAP = 8'haa;
  localparam logic [7:0] AFR_SNAP_CTRL = 8'h03;
  localparam int AFR_MAX_TAGS = 3;

  // ---------------------------------------------------------------
  // action field layout
  // ---------------------------------------------------------------
  localparam int AFR_RT_MODE_W = 4;
  localparam int AFR_RT_SWAP_BIT = 3;
  localparam int AFR_RT_OVL_BIT = 2;
  localparam int AFR_RT_MC_BIT = 1;
  localparam int AFR_RT_UC_BIT = 0;
  localparam logic [1:0] AFR_RT_HI_OVL = 2'h1;
  localparam int AFR_PT_ENA_BIT = 0;
  localparam int AFR_PT_IDX_LO = 1;
  localparam int AFR_PT_IDX_W = 6;
  localparam int AFR_POL_ENA_BIT = 16;
  localparam int AFR_POL_IDX_LO = 17;
  localparam int AFR_POL_IDX_W = 10;
  localparam int AFR_DOM_SEL_W = 2;
  localparam int AFR_SIP_TBL_DEPTH = 1024;

  // swapping sub-modes
  localparam logic [2:0] AFR_SUB_REPL_DMAC = 3'h0;
  localparam logic [2:0] AFR_SUB_REPL_SMAC = 3'h1;
  localparam logic [2:0] AFR_SUB_SWAP_A = 3'h2;
  localparam logic [2:0] AFR_SUB_SWAP_B = 3'h3;
  localparam logic [2:0] AFR_SUB_SWAP_C = 3'h4;
  localparam logic [2:0] AFR_SUB_COND = 3'h5;
  localparam logic [2:0] AFR_SUB_IP_SWAP = 3'h6;
  localparam logic [2:0] AFR_SUB_SMAC_IP = 3'h7;

  // nine frame types
  typedef enum logic [3:0] {
    AFR_FT_IP6_MC, AFR_FT_IP6_UC, AFR_FT_IP4_MC, AFR_FT_IP4_UC, AFR_FT_ARP,
    AFR_FT_OAM, AFR_FT_SNAP, AFR_FT_LLC, AFR_FT_ETYPE
  } afr_ftype_e;

  typedef enum logic [1:0] {
    AFR_L4_OTHER, AFR_L4_TCP, AFR_L4_UDP
  } afr_l4_e;

  // parsed header fields from the upstream parser
  typedef struct packed {
    logic [AFR_MAX_TAGS:0][15:0] type_words; // word 0 outer, tags first
    logic [3:0] ip_version;
    logic [127:0] dip;      // v4 address sits in bits 31:0
    logic [127:0] sip;
    logic [7:0] ip_proto;
    logic [47:0] dmac;
    logic [47:0] smac;
    logic [7:0] dsap;
    logic [7:0] ssap;
    logic [7:0] llc_ctrl;
  } afr_hdr_s;

  // action fields from the match table
  typedef struct packed {
    logic [AFR_RT_MODE_W-1:0] routing_rewrite_mode;
    logic [47:0] action_mac_value;
    logic [AFR_DOM_SEL_W-1:0] timing_domain_select;
    logic [AFR_POL_IDX_W-1:0] policer_index;
  } afr_act_s;

  // decoded result for the action and rewriter stages
  typedef struct packed {
    afr_ftype_e frame_type;
    afr_l4_e l4_type;
    logic uc_route_ena;
    logic mc_route_ena;
    logic pass_through_override_enable;
    logic [AFR_PT_IDX_W-1:0] pass_through_control_index;
    logic dual_bucket_policer_ena;
    logic [AFR_POL_IDX_W-1:0] dual_bucket_policer_index;
    logic [AFR_DOM_SEL_W-1:0] timing_domain_select;
    logic [47:0] new_dmac;
    logic [47:0] new_smac;
    logic [127:0] new_dip;
    logic [127:0] new_sip;
    logic mac_changed;
    logic ip_changed;
  } afr_res_s;

endpackage : afr_pkg

//--- design/afr_classify_rewrite.sv
// frame-type classifier and rewrite-action decoder, one pipeline stage
`timescale 1ns/100ps
module afr_classify_rewrite
  import afr_pkg::*;
#(
  parameter int SIP_DEPTH = AFR_SIP_TBL_DEPTH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // parsed frame and matched action
  input wire logic in_valid_i,
  input wire afr_hdr_s hdr_i,
  input wire afr_act_s act_i,
  // replacement source ip table write port
  input wire logic sip_wr_i,
  input wire logic [$clog2(SIP_DEPTH)-1:0] sip_wr_idx_i,
  input wire logic [127:0] sip_wr_data_i,
  // decoded result
  output logic out_valid_o,
  output afr_res_s res_o
);

  // ---------------------------------------------------------------
  // replacement source ip table
  // ---------------------------------------------------------------
  logic [127:0] sip_tbl [SIP_DEPTH];
  localparam int SIP_AW = $clog2(SIP_DEPTH);

  // table has no reset; software fills it before enabling rewrites
  always_ff @(posedge sys_clk_i) begin
    if (sip_wr_i) begin
      sip_tbl[sip_wr_idx_i] <= sip_wr_data_i;
    end
  end

  // ---------------------------------------------------------------
  // classification
  // ---------------------------------------------------------------
  logic [15:0] type_len;
  afr_ftype_e ftype;
  afr_l4_e l4;
  logic ip_frame;

  // [R23] skip vlan tags
  always_comb begin
    logic found;
    found = 1'b0;
    type_len = hdr_i.type_words[AFR_MAX_TAGS];
    for (int i = 0; i <= AFR_MAX_TAGS; i++) begin
      if (!found && hdr_i.type_words[i] != AFR_ET_VLAN_C &&
          hdr_i.type_words[i] != AFR_ET_VLAN_S) begin
        type_len = hdr_i.type_words[i];
        found = 1'b1;
      end
    end
  end

  // [R14] one of nine types; ip version mismatch falls to etype
  always_comb begin
    ip_frame = 1'b0;
    if (type_len < AFR_LEN_LIMIT) begin
      // [R20] snap header
      if (hdr_i.dsap == AFR_SNAP_SAP && hdr_i.ssap == AFR_SNAP_SAP &&
          hdr_i.llc_ctrl == AFR_SNAP_CTRL) begin
        ftype = AFR_FT_SNAP;
      end else begin
        // [R21] plain llc
        ftype = AFR_FT_LLC;
      end
    end else if (type_len == AFR_ET_IPV6 && hdr_i.ip_version == AFR_IPVER_6) begin
      // [R15] ipv6 multicast prefix
      ip_frame = 1'b1;
      ftype = (hdr_i.dip[127:120] == AFR_V6_MC_PFX) ? AFR_FT_IP6_MC : AFR_FT_IP6_UC;
    end else if (type_len == AFR_ET_IPV4 && hdr_i.ip_version == AFR_IPVER_4) begin
      // [R16] ipv4 class d
      ip_frame = 1'b1;
      ftype = (hdr_i.dip[31:28] == AFR_V4_MC_PFX) ? AFR_FT_IP4_MC : AFR_FT_IP4_UC;
    end else if (type_len == AFR_ET_ARP || type_len == AFR_ET_RARP) begin
      // [R18] address resolution
      ftype = AFR_FT_ARP;
    end else if (type_len == AFR_ET_OAM) begin
      // [R19] oam
      ftype = AFR_FT_OAM;
    end else begin
      // [R22] generic ethertype
      ftype = AFR_FT_ETYPE;
    end
  end

  // [R17] l4 subtype
  always_comb begin
    if (!ip_frame) begin
      l4 = AFR_L4_OTHER;
    end else if (hdr_i.ip_proto == AFR_PROTO_TCP) begin
      l4 = AFR_L4_TCP;
    end else if (hdr_i.ip_proto == AFR_PROTO_UDP) begin
      l4 = AFR_L4_UDP;
    end else begin
      l4 = AFR_L4_OTHER;
    end
  end

  // ---------------------------------------------------------------
  // rewrite-action decode
  // ---------------------------------------------------------------
  logic [AFR_RT_MODE_W-1:0] mode;
  logic [47:0] amac;
  logic swap_mode;
  logic [2:0] sub;
  logic [127:0] repl_sip;
  logic dmac_mc;
  logic smac_mc;
  logic dip_mc;
  logic sip_mc;
  logic [SIP_AW-1:0] pol_idx;
  afr_res_s res_next;

  assign mode = act_i.routing_rewrite_mode;
  assign amac = act_i.action_mac_value;
  assign swap_mode = mode[AFR_RT_SWAP_BIT];
  assign sub = mode[2:0];
  // group bit of the mac is the lsb of the first octet
  assign dmac_mc = hdr_i.dmac[40];
  assign smac_mc = hdr_i.smac[40];
  assign dip_mc = (ftype == AFR_FT_IP4_MC) || (ftype == AFR_FT_IP6_MC);
  // multicast test for a sip that would become the new destination address
  assign sip_mc = ip_frame && ((ftype == AFR_FT_IP6_MC || ftype == AFR_FT_IP6_UC) ?
                  (hdr_i.sip[127:120] == AFR_V6_MC_PFX) :
                  (hdr_i.sip[31:28] == AFR_V4_MC_PFX));

  // [R10] policer index selects the table entry
  assign pol_idx = act_i.policer_index[SIP_AW-1:0];
  assign repl_sip = sip_tbl[pol_idx];

  // address rewrite selection
  always_comb begin
    afr_res_s r;
    r = '0;
    r.frame_type = ftype;
    r.l4_type = l4;
    // [R13] domain select passed to delay response handling
    r.timing_domain_select = act_i.timing_domain_select;
    r.new_dmac = hdr_i.dmac;
    r.new_smac = hdr_i.smac;
    r.new_dip = hdr_i.dip;
    r.new_sip = hdr_i.sip;
    // [R1] zero mode means no change
    if (mode != '0 && !swap_mode) begin
      // [R2] routing update enables
      r.uc_route_ena = mode[AFR_RT_UC_BIT];
      r.mc_route_ena = mode[AFR_RT_MC_BIT];
      // [R3] overloaded mac fields
      if (mode[AFR_RT_OVL_BIT]) begin
        // [R11] pass-through override
        if (mode[3:2] == AFR_RT_HI_OVL) begin
          r.pass_through_override_enable = amac[AFR_PT_ENA_BIT];
          r.pass_through_control_index = amac[AFR_PT_IDX_LO +: AFR_PT_IDX_W];
        end
        // [R12] dual-bucket policer index
        r.dual_bucket_policer_ena = amac[AFR_POL_ENA_BIT];
        r.dual_bucket_policer_index = amac[AFR_POL_IDX_LO +: AFR_POL_IDX_W];
      end
    end else if (swap_mode) begin
      // [R9] replacement mac from action value
      case (sub)
        // [R4] single replacements
        AFR_SUB_REPL_DMAC: r.new_dmac = amac;
        AFR_SUB_REPL_SMAC: r.new_smac = amac;
        // [R5] mac swap with multicast fallback
        AFR_SUB_SWAP_A, AFR_SUB_SWAP_B, AFR_SUB_SWAP_C: begin
          r.new_dmac = hdr_i.smac;
          r.new_smac = dmac_mc ? amac : hdr_i.dmac;
        end
        // [R6] conditional on destination
        AFR_SUB_COND: begin
          if (!dmac_mc) begin
            r.new_dmac = hdr_i.smac;
            r.new_smac = hdr_i.dmac;
          end else begin
            r.new_smac = amac;
          end
          if (ip_frame) begin
            if (!dip_mc) begin
              r.new_dip = hdr_i.sip;
              r.new_sip = hdr_i.dip;
            end else begin
              r.new_sip = repl_sip;
            end
          end
        end
        // [R7] ip swap only
        AFR_SUB_IP_SWAP: begin
          if (ip_frame) begin
            r.new_dip = hdr_i.sip;
            r.new_sip = dip_mc ? repl_sip : hdr_i.dip;
          end
        end
        // [R8] smac replace plus ip swap
        default: begin
          r.new_smac = amac;
          if (ip_frame) begin
            r.new_dip = hdr_i.sip;
            r.new_sip = dip_mc ? repl_sip : hdr_i.dip;
          end
        end
      endcase
    end
    r.mac_changed = (r.new_dmac != hdr_i.dmac) || (r.new_smac != hdr_i.smac);
    r.ip_changed = (r.new_dip != hdr_i.dip) || (r.new_sip != hdr_i.sip);
    res_next = r;
  end

  // ---------------------------------------------------------------
  // output registers
  // ---------------------------------------------------------------
  logic out_valid_reg;
  afr_res_s res_reg;

  // one-cycle latency; result holds until the next valid frame
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      out_valid_reg <= 1'b0;
    end else begin
      out_valid_reg <= in_valid_i;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      res_reg <= '0;
    end else if (in_valid_i) begin
      res_reg <= res_next;
    end
  end

  assign out_valid_o = out_valid_reg;
  assign res_o = res_reg;

  // sip_mc kept for sub-modes where source becomes destination check
  logic unused_ok;
  assign unused_ok = sip_mc & smac_mc;

endmodule : afr_classify_rewrite

//--- tb/afr_classify_rewrite_checker.sv
// port checker for the classifier and rewrite decoder
`timescale 1ns/100ps
module afr_classify_rewrite_checker
  import afr_pkg::*;
#(
  parameter int SIP_DEPTH = AFR_SIP_TBL_DEPTH
) (
  // clock and reset
  input wire logic sys_clk_i,
  input wire logic rst_i,
  // frame side
  input wire logic in_valid_i,
  input wire afr_hdr_s hdr_i,
  input wire afr_act_s act_i,
  input wire logic sip_wr_i,
  input wire logic [$clog2(SIP_DEPTH)-1:0] sip_wr_idx_i,
  input wire logic [127:0] sip_wr_data_i,
  // result side
  input wire logic out_valid_o,
  input wire afr_res_s res_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (rst_i);
  // mode shorthand
  wire logic [3:0] md = act_i.routing_rewrite_mode;
  wire logic [47:0] am = act_i.action_mac_value;

  chk_answer_delay:
    assert property (in_valid_i |=> out_valid_o) else $error("result valid missing");
  chk_no_spurious:
    assert property (!in_valid_i |=> !out_valid_o) else $error("result valid unasked");
  chk_result_hold:
    assert property (!out_valid_o |-> $stable(res_o)) else $error("result moved idle");
  chk_mode_zero:
    assert property (in_valid_i && md == 4'h0 |=> !res_o.uc_route_ena && !res_o.mc_route_ena
      && res_o.new_smac == $past(hdr_i.smac)) else $error("mode zero changed frame");
  chk_route_bits:
    assert property (in_valid_i && !md[3] |=> res_o.uc_route_ena == $past(md[0])
      && res_o.mc_route_ena == $past(md[1])) else $error("route enables wrong");
  chk_swap_noroute:
    assert property (in_valid_i && md[3] |=> !res_o.uc_route_ena && !res_o.mc_route_ena)
      else $error("route enable in swap mode");
  chk_pt_fields:
    assert property (in_valid_i && md[3:2] == 2'h1 |=> res_o.pass_through_override_enable
      == $past(am[0]) && res_o.pass_through_control_index == $past(am[6:1]))
      else $error("pass-through fields wrong");
  chk_pol_index:
    assert property (in_valid_i && md[3:2] == 2'h1 && am[16] |=> res_o.dual_bucket_policer_ena
      && res_o.dual_bucket_policer_index == $past(am[26:17])) else $error("policer wrong");
  chk_dom_sel:
    assert property (in_valid_i |=> res_o.timing_domain_select
      == $past(act_i.timing_domain_select)) else $error("domain select wrong");
  chk_repl_dmac:
    assert property (in_valid_i && md == 4'h8 |=> res_o.new_dmac == $past(am))
      else $error("dmac not replaced");
  chk_oam_type:
    assert property (in_valid_i && hdr_i.type_words[0] == AFR_ET_OAM
      |=> res_o.frame_type == AFR_FT_OAM) else $error("oam not classed");
  // main scenarios
  cov_swap: cover property (in_valid_i && md[3]);
  cov_snap: cover property (out_valid_o && res_o.frame_type == AFR_FT_SNAP);
  cov_b2b: cover property (in_valid_i [*2]);
endmodule : afr_classify_rewrite_checker

bind afr_classify_rewrite afr_classify_rewrite_checker #(.SIP_DEPTH(SIP_DEPTH)) i_chk (
  .sys_clk_i(sys_clk_i), .rst_i(rst_i), .in_valid_i(in_valid_i), .hdr_i(hdr_i),
  .act_i(act_i), .sip_wr_i(sip_wr_i), .sip_wr_idx_i(sip_wr_idx_i),
  .sip_wr_data_i(sip_wr_data_i), .out_valid_o(out_valid_o), .res_o(res_o));

//--- tb/afr_action_sink.sv
// downstream rewriter model: latches every result handed to it
`timescale 1ns/100ps
module afr_action_sink
  import afr_pkg::*;
(
  // clock and result
  input wire logic sys_clk_i,
  input wire logic valid_i,
  input wire afr_res_s res_i,
  // captured view
  output afr_res_s seen_o,
  output logic [7:0] count_o = 8'h00
);
  // no back-pressure, so a lost pulse shows up in the count
  always @(posedge sys_clk_i) begin
    if (valid_i) begin
      seen_o <= res_i;
      count_o <= count_o + 8'h01;
    end
  end
endmodule : afr_action_sink

//--- tb/test_afr_classify_rewrite.sv
// self-checking bench for the classifier and rewrite decoder
`timescale 1ns/100ps
module test_afr_classify_rewrite
  import afr_pkg::*;
;
  localparam logic [47:0] AMAC = 48'h0000_02ab_0055;
  localparam logic [127:0] TBL = 128'hc0a8_0063;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic in_valid = 1'b0;
  logic sip_wr = 1'b0;
  logic [9:0] sip_idx = 10'h000;
  logic [127:0] sip_dat = 128'h0;
  afr_hdr_s hdr = '0;
  afr_act_s act = '0;
  afr_hdr_s hs;
  afr_act_s ac;
  logic out_valid;
  afr_res_s res;
  afr_res_s seen;
  logic [7:0] seen_n;
  int n_errors = 0;
  int n_checks = 0;

  always #20 sys_clk = ~sys_clk;
  afr_classify_rewrite i_dut (.sys_clk_i(sys_clk), .rst_i(rst), .in_valid_i(in_valid),
    .hdr_i(hdr), .act_i(act), .sip_wr_i(sip_wr), .sip_wr_idx_i(sip_idx),
    .sip_wr_data_i(sip_dat), .out_valid_o(out_valid), .res_o(res));
  afr_action_sink i_sink (.sys_clk_i(sys_clk), .valid_i(out_valid), .res_i(res),
    .seen_o(seen), .count_o(seen_n));

  // ---------------------------------------------------------------
  // shared tasks
  // ---------------------------------------------------------------
  task automatic chk(input string nm, input logic [127:0] e, input logic [127:0] g);
    n_checks++;
    if (g !== e) begin
      n_errors++;
      $display("FAIL %s expected %0h seen %0h", nm, e, g);
    end
  endtask : chk

  // one frame, result looked at inside its one valid cycle
  task automatic send();
    @(negedge sys_clk);
    hdr = hs;
    act = ac;
    in_valid = 1'b1;
    @(negedge sys_clk);
    in_valid = 1'b0;
    chk("out_valid", 1'b1, out_valid);
  endtask : send

  task automatic t_cls(input logic [15:0] t0, t1, input logic [3:0] v, input logic [7:0] d, p,
                       sap, c, input afr_ftype_e ft, input afr_l4_e l4);
    hs = '0;
    ac = '0;
    hs.type_words[0] = t0;
    hs.type_words[1] = t1;
    hs.ip_version = v;
    hs.dip = {d, 88'h0, d, 24'h0};
    hs.ip_proto = p;
    hs.dsap = sap;
    hs.ssap = sap;
    hs.llc_ctrl = c;
    hs.dmac = 48'h0000_1234_5678;
    send();
    chk("frame_type", ft, res.frame_type);
    chk("l4_type", l4, res.l4_type);
    chk("new_dmac", hs.dmac, res.new_dmac);
    chk("mac_changed", 1'b0, res.mac_changed);
    chk("ip_changed", 1'b0, res.ip_changed);
  endtask : t_cls

  task automatic t_route(input logic [2:0] m);
    hs = '0;
    ac = '0;
    ac.routing_rewrite_mode = {1'b0, m};
    ac.action_mac_value = AMAC;
    ac.timing_domain_select = m[1:0];
    hs.smac = 48'h0000_0000_0abc;
    send();
    chk("uc_route", m[0], res.uc_route_ena);
    chk("mc_route", m[1], res.mc_route_ena);
    chk("dom_sel", m[1:0], res.timing_domain_select);
    chk("new_smac", hs.smac, res.new_smac);
    // overloaded fields must stay clear when bit 2 is off
    chk("pt_ena", m[2], res.pass_through_override_enable);
    chk("pt_idx", m[2] ? 6'h2a : 6'h00, res.pass_through_control_index);
    chk("pol_ena", m[2], res.dual_bucket_policer_ena);
    chk("pol_idx", m[2] ? 10'h155 : 10'h000, res.dual_bucket_policer_index);
  endtask : t_route

  // multicast destinations drive the replace-instead-of-swap fallbacks
  task automatic t_swap(input logic [2:0] m, input logic mc);
    logic [47:0] ed;
    logic [47:0] es;
    logic [127:0] edi;
    logic [127:0] esi;
    hs = '0;
    ac = '0;
    hs.type_words[0] = AFR_ET_IPV4;
    hs.ip_version = AFR_IPVER_4;
    hs.dmac = {7'h00, mc, 40'h11_2222_3333};
    hs.smac = 48'h0200_4444_5555;
    hs.dip = {96'h0, mc ? 8'he1 : 8'h0a, 24'h000001};
    hs.sip = 128'h0a00_0002;
    ac.routing_rewrite_mode = {1'b1, m};
    ac.action_mac_value = AMAC;
    ac.policer_index = 10'h155;
    ed = hs.dmac;
    es = hs.smac;
    edi = hs.dip;
    esi = hs.sip;
    case (m)
      3'h0: ed = AMAC;
      3'h1: es = AMAC;
      3'h5: begin
        es = mc ? AMAC : hs.dmac;
        ed = mc ? hs.dmac : hs.smac;
        edi = mc ? hs.dip : hs.sip;
        esi = mc ? TBL : hs.dip;
      end
      3'h6: begin
        edi = hs.sip;
        esi = mc ? TBL : hs.dip;
      end
      3'h7: begin
        es = AMAC;
        edi = hs.sip;
        esi = mc ? TBL : hs.dip;
      end
      default: begin
        ed = hs.smac;
        es = mc ? AMAC : hs.dmac;
      end
    endcase
    send();
    chk("new_smac", es, res.new_smac);
    chk("new_sip", esi, res.new_sip);
    chk("new_dmac", ed, res.new_dmac);
    chk("new_dip", edi, res.new_dip);
    chk("mac_changed", (ed != hs.dmac) || (es != hs.smac), res.mac_changed);
    chk("ip_changed", (edi != hs.dip) || (esi != hs.sip), res.ip_changed);
  endtask : t_swap

  task automatic t_b2b();
    logic [7:0] n0;
    // sample only after the previous frame's result has reached the sink
    @(negedge sys_clk);
    n0 = seen_n;
    hdr = '0;
    act = '0;
    hdr.type_words[0] = AFR_ET_OAM;
    in_valid = 1'b1;
    @(negedge sys_clk);
    hdr.type_words[0] = AFR_ET_RARP;
    chk("b2b_first", AFR_FT_OAM, res.frame_type);
    @(negedge sys_clk);
    in_valid = 1'b0;
    chk("b2b_second", AFR_FT_ARP, res.frame_type);
    @(negedge sys_clk);
    chk("sink_count", n0 + 8'h02, seen_n);
    chk("sink_type", AFR_FT_ARP, seen.frame_type);
  endtask : t_b2b

  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, n_errors);
    if (n_errors == 0 && n_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    repeat (5) @(negedge sys_clk);
    rst = 1'b0;
    sip_idx = 10'h155;
    sip_dat = TBL;
    sip_wr = 1'b1;
    @(negedge sys_clk);
    sip_idx = 10'h000;
    sip_dat = 128'h0a00_00ff;
    @(negedge sys_clk);
    sip_wr = 1'b0;
    t_cls(16'h86dd, 16'h0, 4'h6, 8'hff, 8'h06, 8'h0, 8'h0, AFR_FT_IP6_MC, AFR_L4_TCP);
    t_cls(16'h86dd, 16'h0, 4'h6, 8'h20, 8'h11, 8'h0, 8'h0, AFR_FT_IP6_UC, AFR_L4_UDP);
    t_cls(16'h0800, 16'h0, 4'h4, 8'he0, 8'h01, 8'h0, 8'h0, AFR_FT_IP4_MC, AFR_L4_OTHER);
    t_cls(16'h0800, 16'h0, 4'h4, 8'hdf, 8'h06, 8'h0, 8'h0, AFR_FT_IP4_UC, AFR_L4_TCP);
    t_cls(16'h0806, 16'h0, 4'h0, 8'h0, 8'h0, 8'h0, 8'h0, AFR_FT_ARP, AFR_L4_OTHER);
    t_cls(16'h8035, 16'h0, 4'h0, 8'h0, 8'h0, 8'h0, 8'h0, AFR_FT_ARP, AFR_L4_OTHER);
    t_cls(16'h05ff, 16'h0, 4'h0, 8'h0, 8'h0, 8'haa, 8'h03, AFR_FT_SNAP, AFR_L4_OTHER);
    t_cls(16'h0040, 16'h0, 4'h0, 8'h0, 8'h0, 8'haa, 8'h13, AFR_FT_LLC, AFR_L4_OTHER);
    t_cls(16'h0600, 16'h0, 4'h0, 8'h0, 8'h0, 8'haa, 8'h03, AFR_FT_ETYPE, AFR_L4_OTHER);
    t_cls(16'h8100, 16'h0800, 4'h4, 8'h0a, 8'h11, 8'h0, 8'h0, AFR_FT_IP4_UC, AFR_L4_UDP);
    for (int m = 0; m < 8; m++) t_route(m[2:0]);
    for (int m = 0; m < 16; m++) t_swap(m[2:0], m[3]);
    t_b2b();
    complete_run();
  end

  initial begin
    repeat (5000) @(posedge sys_clk);
    n_errors++;
    complete_run();
  end
endmodule : test_afr_classify_rewrite
